// *** mtr_top.sv ***
// Purpose: Memory type resolver with attribute table behind an APB slave
// Assumes: Walker and access inputs synchronous to CLK
// Notes:   Request and its resolved type leave together one cycle after entry
//
// How it works
// - High index bit is entry bit 7 for leaf, bit 12 for large page.
// - Entries without a high index bit use zero for it.
// - Cache-disable is entry bit 4, writethrough is entry bit 3.
// - Slot index is high bit, cache-disable, writethrough, most significant first.
// - Reset loads write-back, write-through, weak uncached, strict uncached, twice.
// - Slots hold only the six supported type encodings.
// - Bad encoding or reserved bits raise a fault and leave the table alone.
// - Feature result bit 16 set for query function 1 or 8000_0001h.
// - Table lookup is always on; no disable control exists.
// - Index bits captured at translation select the slot applied to the access.
// - Upper-level fetches use only the first four slots.
// - Weak uncached gives write-combining for such range, otherwise strict uncached.
// - Strict, combining fixed; write-back follows range; write-through kept for through or back ranges, else uncached.
// - Write-protect gives write-protect for protect or back ranges, else uncached.
// - Any undefined combination resolves to strict uncached.
// - Disabled range registers act as strict uncached range.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module mtr_top
    import mtr_pkg::*;
(
    input  wire logic                     CLK,
    input  wire logic                     SYS_RST,
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [11:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic [31:0]                   PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    input  wire logic                     WALK_VALID,
    input  wire mtr_pkg::mtr_level_e      WALK_LEVEL,
    input  wire logic [mtr_pkg::ENT_W-1:0] WALK_ENTRY,
    output logic                          FETCH_VALID,
    output logic [2:0]                    FETCH_TYPE,
    input  wire logic                     ACC_VALID,
    input  wire logic [2:0]               RANGE_TYPE,
    input  wire logic                     RANGE_EN,
    output logic                          ACC_OUT_VALID,
    output logic [2:0]                    ACC_TYPE,
    output logic                          PROT_FAULT
);
    import mtr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic word_ok(input logic [31:0] w);
        logic ok;
        ok = 1'b1;
        for (int b = 0; b < 4; b++) begin
            if (w[b*SLOT_STRIDE+TYPE_W +: SLOT_STRIDE-TYPE_W] != '0) begin
                ok = 1'b0;
            end
            case (w[b*SLOT_STRIDE +: TYPE_W])
                MT_UNCACHED_STRICT, MT_WRITE_COMBINING, MT_WRITE_THROUGH,
                MT_WRITE_PROTECT, MT_WRITE_BACK, MT_UNCACHED_WEAK: ;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    function automatic logic [2:0] slot_of(input logic [63:0] t, input logic [2:0] i);
        return t[i*SLOT_STRIDE +: TYPE_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [63:0] table_reg;
    logic [31:0] feat_func_reg;
    logic        fault_reg;
    logic [2:0]  idx_reg;
    logic        setup;
    logic        access;
    logic        wr_lo;
    logic        wr_hi;
    logic        bad_wr;
    logic        mapped;
    logic [31:0] rd_next;
    logic        feat_hit;

    assign setup    = PSEL && !PENABLE;
    assign access   = PSEL && PENABLE && PREADY;
    assign feat_hit = (feat_func_reg == FEAT_FUNC_STD) || (feat_func_reg == FEAT_FUNC_EXT);
    assign mapped   = (PADDR == OFS_TABLE_LO) || (PADDR == OFS_TABLE_HI) || (PADDR == OFS_FEAT_FUNC) ||
                      (PADDR == OFS_FEAT_RESULT) || (PADDR == OFS_STATUS);
    assign bad_wr   = PWRITE && ((PADDR == OFS_TABLE_LO) || (PADDR == OFS_TABLE_HI)) && !word_ok(PWDATA);
    assign wr_lo    = access && PWRITE && (PADDR == OFS_TABLE_LO) && !PSLVERR;
    assign wr_hi    = access && PWRITE && (PADDR == OFS_TABLE_HI) && !PSLVERR;

    always_comb begin
        rd_next = 32'h00000000;
        case (PADDR)
            OFS_TABLE_LO:    rd_next = table_reg[31:0];
            OFS_TABLE_HI:    rd_next = table_reg[63:32];
            OFS_FEAT_FUNC:   rd_next = feat_func_reg;
            OFS_FEAT_RESULT: rd_next[FEAT_TABLE_BIT] = feat_hit;
            OFS_STATUS: begin
                rd_next[STAT_FAULT_BIT] = fault_reg;
                rd_next[STAT_IDX_LSB +: 3] = idx_reg;
            end
            default:         rd_next = 32'h00000000;
        endcase
    end

    // No wait state: answer prepared in setup, ready in the first access cycle
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end
        else begin
            PREADY <= setup;
            if (setup) begin
                PSLVERR <= !mapped || bad_wr;
                PRDATA  <= PWRITE ? 32'h00000000 : rd_next;
            end
            else if (access) begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // No enable bit exists: the table is always consulted
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            table_reg <= TABLE_RESET;
        end
        else if (wr_lo) begin
            table_reg[31:0] <= PWDATA;
        end
        else if (wr_hi) begin
            table_reg[63:32] <= PWDATA;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            feat_func_reg <= 32'h00000000;
        end
        else if (access && PWRITE && PADDR == OFS_FEAT_FUNC) begin
            feat_func_reg <= PWDATA;
        end
    end

    // Fault pulse and sticky flag; a new fault wins over a clear
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PROT_FAULT <= 1'b0;
            fault_reg  <= 1'b0;
        end
        else begin
            PROT_FAULT <= access && bad_wr;
            if (access && bad_wr) begin
                fault_reg <= 1'b1;
            end
            else if (access && PWRITE && PADDR == OFS_STATUS && PWDATA[STAT_FAULT_BIT]) begin
                fault_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Translation and access

    logic [2:0] walk_idx;
    logic [2:0] fetch_eff;
    logic [2:0] acc_eff;

    mtr_index u_index (
        .entry (WALK_ENTRY),
        .level (WALK_LEVEL),
        .idx   (walk_idx)
    );

    mtr_combine u_fetch_comb (
        .slot_type  (slot_of(table_reg, walk_idx)),
        .range_type (RANGE_TYPE),
        .range_en   (RANGE_EN),
        .eff_type   (fetch_eff)
    );

    mtr_combine u_acc_comb (
        .slot_type  (slot_of(table_reg, idx_reg)),
        .range_type (RANGE_TYPE),
        .range_en   (RANGE_EN),
        .eff_type   (acc_eff)
    );

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            idx_reg <= 3'h0;
        end
        else if (WALK_VALID && WALK_LEVEL != LVL_UPPER) begin
            idx_reg <= walk_idx;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            FETCH_VALID <= 1'b0;
            FETCH_TYPE  <= MT_UNCACHED_STRICT;
        end
        else begin
            FETCH_VALID <= WALK_VALID && WALK_LEVEL == LVL_UPPER;
            if (WALK_VALID && WALK_LEVEL == LVL_UPPER) begin
                FETCH_TYPE <= fetch_eff;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ACC_OUT_VALID <= 1'b0;
            ACC_TYPE      <= MT_UNCACHED_STRICT;
        end
        else begin
            ACC_OUT_VALID <= ACC_VALID;
            if (ACC_VALID) begin
                ACC_TYPE <= acc_eff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_RESET_TABLE: assert property (@(posedge CLK) $fell(SYS_RST) |-> table_reg == TABLE_RESET)
        else $error("table not at reset values");

    AST_FAULT_KEEP: assert property (@(posedge CLK) disable iff (SYS_RST)
        access && bad_wr |=> $stable(table_reg))
        else $error("table changed by a rejected write");

    AST_FAULT_PULSE: assert property (@(posedge CLK) disable iff (SYS_RST)
        access && bad_wr |=> PROT_FAULT ##1 !PROT_FAULT)
        else $error("fault pulse missing or too long");

    AST_SLOTS_LEGAL: assert property (@(posedge CLK) disable iff (SYS_RST)
        word_ok(table_reg[31:0]) && word_ok(table_reg[63:32]))
        else $error("table holds an unsupported encoding");

    AST_FEATURE: assert property (@(posedge CLK) disable iff (SYS_RST)
        setup && !PWRITE && PADDR == OFS_FEAT_RESULT && feat_func_reg == FEAT_FUNC_EXT
        |=> PREADY && PRDATA[FEAT_TABLE_BIT])
        else $error("feature bit not reported");

    AST_FEATURE_STD: assert property (@(posedge CLK) disable iff (SYS_RST)
        setup && !PWRITE && PADDR == OFS_FEAT_RESULT && feat_func_reg == FEAT_FUNC_STD
        |=> PREADY && PRDATA[FEAT_TABLE_BIT])
        else $error("feature bit not reported for standard query");

    AST_FEATURE_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
        setup && !PWRITE && PADDR == OFS_FEAT_RESULT
        && feat_func_reg != FEAT_FUNC_STD && feat_func_reg != FEAT_FUNC_EXT
        |=> PREADY && !PRDATA[FEAT_TABLE_BIT])
        else $error("feature bit reported for another query");

    AST_CAPTURE: assert property (@(posedge CLK) disable iff (SYS_RST)
        WALK_VALID && WALK_LEVEL == LVL_LARGE
        |=> idx_reg == {$past(WALK_ENTRY[ENT_HI_BIT_LARGE]), $past(WALK_ENTRY[ENT_CD_BIT]),
                        $past(WALK_ENTRY[ENT_WT_BIT])})
        else $error("index not captured from large page entry");

    AST_CAPTURE_LEAF: assert property (@(posedge CLK) disable iff (SYS_RST)
        WALK_VALID && WALK_LEVEL == LVL_LEAF
        |=> idx_reg == {$past(WALK_ENTRY[ENT_HI_BIT_LEAF]), $past(WALK_ENTRY[ENT_CD_BIT]),
                        $past(WALK_ENTRY[ENT_WT_BIT])})
        else $error("index not captured from leaf entry");

    AST_UPPER_LOW4: assert property (@(posedge CLK) disable iff (SYS_RST)
        WALK_VALID && WALK_LEVEL == LVL_UPPER |-> !walk_idx[2])
        else $error("upper level reached upper slots");

    AST_FETCH_OUT: assert property (@(posedge CLK) disable iff (SYS_RST)
        WALK_VALID && WALK_LEVEL == LVL_UPPER |=> FETCH_VALID)
        else $error("upper level fetch type not presented");

    AST_ACC_TOGETHER: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID && slot_of(table_reg, idx_reg) == MT_UNCACHED_STRICT
        |=> ACC_OUT_VALID && ACC_TYPE == MT_UNCACHED_STRICT)
        else $error("strict uncached slot not honoured");

    AST_ACC_OUT: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID |=> ACC_OUT_VALID)
        else $error("access left without its type");

    AST_ACC_IDLE: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ACC_VALID |=> !ACC_OUT_VALID)
        else $error("access output without a request");

    AST_RANGE_OFF: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID && !RANGE_EN && slot_of(table_reg, idx_reg) == MT_WRITE_BACK
        |=> ACC_TYPE == MT_UNCACHED_STRICT)
        else $error("disabled range did not default to uncached");

    AST_RANGE_RSVD: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID && RANGE_EN && (RANGE_TYPE == 3'h2 || RANGE_TYPE == 3'h3 || RANGE_TYPE == 3'h7)
        && slot_of(table_reg, idx_reg) == MT_WRITE_BACK |=> ACC_TYPE == MT_UNCACHED_STRICT)
        else $error("undefined range type not resolved to uncached");

    AST_WB_FOLLOWS: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID && RANGE_EN && RANGE_TYPE == MT_WRITE_PROTECT
        && slot_of(table_reg, idx_reg) == MT_WRITE_BACK |=> ACC_TYPE == MT_WRITE_PROTECT)
        else $error("write-back slot did not follow the range type");

    AST_WEAK_WC: assert property (@(posedge CLK) disable iff (SYS_RST)
        ACC_VALID && RANGE_EN && RANGE_TYPE == MT_WRITE_COMBINING
        && slot_of(table_reg, idx_reg) == MT_UNCACHED_WEAK |=> ACC_TYPE == MT_WRITE_COMBINING)
        else $error("weak uncached not overridden by combining range");

endmodule

// *** mtr_pkg.sv ***
// Purpose: Shared constants and types of the memory type resolver
// Assumes: APB register window, 32-bit data, byte offsets
// Notes:   Type encodings are 3 bits; table slots occupy the low bits of each byte
package mtr_pkg;

    typedef logic [2:0] mtr_type_t;
    typedef logic [2:0] mtr_idx_t;

    typedef enum logic [1:0] {
        LVL_LEAF,
        LVL_LARGE,
        LVL_UPPER
    } mtr_level_e;

    // Memory type encodings
    localparam mtr_type_t MT_UNCACHED_STRICT = 3'h0;
    localparam mtr_type_t MT_WRITE_COMBINING = 3'h1;
    localparam mtr_type_t MT_WRITE_THROUGH   = 3'h4;
    localparam mtr_type_t MT_WRITE_PROTECT   = 3'h5;
    localparam mtr_type_t MT_WRITE_BACK      = 3'h6;
    localparam mtr_type_t MT_UNCACHED_WEAK   = 3'h7;

    // Table entry bit positions
    localparam int ENT_HI_BIT_LEAF  = 7;
    localparam int ENT_HI_BIT_LARGE = 12;
    localparam int ENT_CD_BIT       = 4;
    localparam int ENT_WT_BIT       = 3;
    localparam int ENT_W            = 13;

    // Table layout
    localparam int SLOT_NUM    = 8;
    localparam int SLOT_STRIDE = 8;
    localparam int TYPE_W      = 3;
    localparam logic [63:0] TABLE_RESET = 64'h0007040600070406;

    // Register byte offsets
    localparam logic [11:0] OFS_TABLE_LO    = 12'h000;
    localparam logic [11:0] OFS_TABLE_HI    = 12'h004;
    localparam logic [11:0] OFS_FEAT_FUNC   = 12'h008;
    localparam logic [11:0] OFS_FEAT_RESULT = 12'h00C;
    localparam logic [11:0] OFS_STATUS      = 12'h010;

    // Feature query
    localparam logic [31:0] FEAT_FUNC_STD  = 32'h00000001;
    localparam logic [31:0] FEAT_FUNC_EXT  = 32'h80000001;
    localparam int          FEAT_TABLE_BIT = 16;

    // Status fields
    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_IDX_LSB   = 4;

endpackage

// *** mtr_index.sv ***
// Purpose: Forms the 3-bit slot index from a table entry
// Assumes: Entry bits are stable while the walker presents them
// Notes:   Purely combinational
`timescale 1ns/1ps
module mtr_index
    import mtr_pkg::*;
(
    input  wire logic [mtr_pkg::ENT_W-1:0] entry,
    input  wire mtr_pkg::mtr_level_e       level,
    output logic [2:0]                     idx
);
    logic hi_bit;

    always_comb begin
        case (level)
            LVL_LEAF:  hi_bit = entry[ENT_HI_BIT_LEAF];
            LVL_LARGE: hi_bit = entry[ENT_HI_BIT_LARGE];
            LVL_UPPER: hi_bit = 1'b0;
            default:   hi_bit = 1'b0;
        endcase
    end

    // Upper levels have no high bit, so only the first four slots are reachable
    assign idx = {hi_bit, entry[ENT_CD_BIT], entry[ENT_WT_BIT]};
endmodule

// *** mtr_combine.sv ***
// Purpose: Merges a table slot type with the range type into the effective type
// Assumes: Range type is only meaningful when range_en is high
// Notes:   Anything not listed falls back to the strict uncached type
`timescale 1ns/1ps
module mtr_combine
    import mtr_pkg::*;
(
    input  wire logic [2:0] slot_type,
    input  wire logic [2:0] range_type,
    input  wire logic       range_en,
    output logic [2:0]      eff_type
);
    logic [2:0] rng;

    always_comb begin
        rng = MT_UNCACHED_STRICT;
        if (range_en) begin
            case (range_type)
                MT_UNCACHED_STRICT, MT_WRITE_COMBINING, MT_WRITE_THROUGH,
                MT_WRITE_PROTECT, MT_WRITE_BACK: rng = range_type;
                default: rng = MT_UNCACHED_STRICT;
            endcase
        end
        else begin
            rng = MT_UNCACHED_STRICT;
        end
        eff_type = MT_UNCACHED_STRICT;
        case (slot_type)
            MT_UNCACHED_STRICT: eff_type = MT_UNCACHED_STRICT;
            MT_WRITE_COMBINING: eff_type = MT_WRITE_COMBINING;
            MT_WRITE_BACK:      eff_type = rng;
            MT_WRITE_THROUGH: begin
                if (rng == MT_WRITE_THROUGH || rng == MT_WRITE_BACK) begin
                    eff_type = MT_WRITE_THROUGH;
                end
                else begin
                    eff_type = MT_UNCACHED_STRICT;
                end
            end
            MT_WRITE_PROTECT: begin
                if (rng == MT_WRITE_PROTECT || rng == MT_WRITE_BACK) begin
                    eff_type = MT_WRITE_PROTECT;
                end
                else begin
                    eff_type = MT_UNCACHED_STRICT;
                end
            end
            MT_UNCACHED_WEAK: begin
                if (rng == MT_WRITE_COMBINING) begin
                    eff_type = MT_WRITE_COMBINING;
                end
                else begin
                    eff_type = MT_UNCACHED_STRICT;
                end
            end
            default: eff_type = MT_UNCACHED_STRICT;
        endcase
    end
endmodule

// *** mtr_walk_model.sv ***
// Purpose: Page walker and access source facing the memory type resolver
// Assumes: Requests start and end on rising edges of clk
// Notes:   Released data lines carry the inverse of the last value
`timescale 1ns/1ps
module mtr_walk_model
    import mtr_pkg::*;
(
    input  wire logic                     clk,
    output logic                          walk_valid,
    output mtr_pkg::mtr_level_e           walk_level,
    output logic [mtr_pkg::ENT_W-1:0]     walk_entry,
    output logic                          acc_valid,
    output logic [2:0]                    range_type,
    output logic                          range_en
);
    import mtr_pkg::*;

    initial begin
        walk_valid = 1'b0;
        walk_level = LVL_LEAF;
        walk_entry = '0;
        acc_valid  = 1'b0;
        range_type = 3'h0;
        range_en   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One walker step, range inputs valid with it
    task automatic walk(input mtr_level_e lvl, input logic [ENT_W-1:0] ent, input logic [2:0] rt, input logic en);
        @(posedge clk);
        walk_valid <= 1'b1;
        walk_level <= lvl;
        walk_entry <= ent;
        range_type <= rt;
        range_en   <= en;
        @(posedge clk);
        walk_valid <= 1'b0;
        walk_entry <= ~ent;
        range_type <= ~rt;
    endtask

    // One access request; the index comes from an earlier walk
    task automatic access(input logic [2:0] rt, input logic en);
        @(posedge clk);
        acc_valid  <= 1'b1;
        range_type <= rt;
        range_en   <= en;
        @(posedge clk);
        acc_valid  <= 1'b0;
        range_type <= ~rt;
    endtask
endmodule

// *** tb.sv ***
// Purpose: Self-checking bench of the memory type resolver
// Assumes: No wait state on any register access
// Notes:   Expected types come from the bench's own merge function
`timescale 1ns/1ps
module tb;
    import mtr_pkg::*;

    logic             clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic             walk_valid, acc_valid, range_en, fetch_valid, acc_out_valid, prot_fault;
    mtr_level_e       walk_level;
    logic [ENT_W-1:0] walk_entry;
    logic [2:0]       range_type, fetch_type, acc_type;
    int               miscompares, checks;

    // Reset slot types, slot 0 first
    localparam mtr_type_t ST [8] = '{MT_WRITE_BACK, MT_WRITE_THROUGH, MT_UNCACHED_WEAK, MT_UNCACHED_STRICT,
                                     MT_WRITE_BACK, MT_WRITE_THROUGH, MT_UNCACHED_WEAK, MT_UNCACHED_STRICT};
    localparam mtr_type_t TY [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};

    mtr_top i_mtr_top (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .WALK_VALID(walk_valid), .WALK_LEVEL(walk_level), .WALK_ENTRY(walk_entry),
        .FETCH_VALID(fetch_valid), .FETCH_TYPE(fetch_type), .ACC_VALID(acc_valid),
        .RANGE_TYPE(range_type), .RANGE_EN(range_en), .ACC_OUT_VALID(acc_out_valid),
        .ACC_TYPE(acc_type), .PROT_FAULT(prot_fault));

    mtr_walk_model i_mtr_walk_model (.clk(clk), .walk_valid(walk_valid), .walk_level(walk_level),
        .walk_entry(walk_entry), .acc_valid(acc_valid), .range_type(range_type), .range_en(range_en));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            report_and_stop;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Merge of slot type and range type
    function automatic logic [2:0] eff(input logic [2:0] s, input logic [2:0] r, input logic en);
        logic [2:0] m;
        m = (!en || r inside {3'h2, 3'h3, 3'h7}) ? MT_UNCACHED_STRICT : r;
        case (s)
            MT_WRITE_COMBINING: return MT_WRITE_COMBINING;
            MT_UNCACHED_WEAK: return (m == MT_WRITE_COMBINING) ? m : MT_UNCACHED_STRICT;
            MT_WRITE_BACK: return m;
            MT_WRITE_THROUGH: return (m inside {MT_WRITE_THROUGH, MT_WRITE_BACK}) ? s : MT_UNCACHED_STRICT;
            MT_WRITE_PROTECT: return (m inside {MT_WRITE_PROTECT, MT_WRITE_BACK}) ? s : MT_UNCACHED_STRICT;
            default: return MT_UNCACHED_STRICT;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, OFS_TABLE_LO, 32'h0);
        chk("table_lo", rd, TABLE_RESET[31:0]);
        apb(1'b0, OFS_TABLE_HI, 32'h0);
        chk("table_hi", rd, TABLE_RESET[63:32]);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0);
    endtask

    task automatic t_feature;
        logic [31:0] f [4] = '{32'h00000001, 32'h80000001, 32'h00000002, 32'h80000000};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_FEAT_FUNC, f[i]);
            apb(1'b0, OFS_FEAT_RESULT, 32'h0);
            chk("feat_bit", rd[FEAT_TABLE_BIT], i < 2);
        end
    endtask

    task automatic t_reject;
        logic [31:0] bad [3] = '{32'h00070402, 32'h00070416, 32'h03070406};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_TABLE_LO, bad[i]);
            chk("rej_err", err, 1'b1);
            @(posedge clk);
            chk("fault", prot_fault, 1'b1);
            @(posedge clk);
            chk("fault_end", prot_fault, 1'b0);
            apb(1'b0, OFS_TABLE_LO, 32'h0);
            chk("kept", rd, TABLE_RESET[31:0]);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("stat_fault", rd[STAT_FAULT_BIT], 1'b1);
        apb(1'b1, OFS_STATUS, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("stat_clr", rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
    endtask

    task automatic t_index;
        logic [ENT_W-1:0] e;
        logic [2:0]       x;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 8; i++) begin
                x = i[2:0];
                e = '0;
                e[k ? ENT_HI_BIT_LARGE : ENT_HI_BIT_LEAF] = x[2];
                e[k ? ENT_HI_BIT_LEAF : ENT_HI_BIT_LARGE] = ~x[2];
                e[ENT_CD_BIT] = x[1];
                e[ENT_WT_BIT] = x[0];
                i_mtr_walk_model.walk(k ? LVL_LARGE : LVL_LEAF, e, MT_WRITE_COMBINING, 1'b1);
                i_mtr_walk_model.access(MT_WRITE_BACK, 1'b1);
                @(posedge clk);
                chk("acc_valid", acc_out_valid, 1'b1);
                chk("acc_type", acc_type, eff(ST[x], MT_WRITE_BACK, 1'b1));
                apb(1'b0, OFS_STATUS, 32'h0);
                chk("stat_idx", rd[STAT_IDX_LSB +: 3], x);
                e[ENT_HI_BIT_LEAF] = 1'b1;
                e[ENT_HI_BIT_LARGE] = 1'b1;
                i_mtr_walk_model.walk(LVL_UPPER, e, MT_WRITE_BACK, 1'b1);
                @(posedge clk);
                chk("fetch_valid", fetch_valid, 1'b1);
                chk("fetch_type", fetch_type, eff(ST[{1'b0, x[1:0]}], MT_WRITE_BACK, 1'b1));
            end
        end
    endtask

    task automatic t_combine;
        logic [2:0] r;
        logic       en;
        for (int j = 0; j < 6; j++) begin
            apb(1'b1, OFS_TABLE_LO, {8'h05, 8'h04, 8'h01, 5'h00, TY[j]});
            chk("slot_err", err, 1'b0);
            // Remap after each table change; no cache sits behind the block to flush
            i_mtr_walk_model.walk(LVL_LEAF, 13'h1000, MT_WRITE_BACK, 1'b1);
            for (int q = 0; q < 9; q++) begin
                r = (q < 8) ? q[2:0] : MT_WRITE_BACK;
                en = (q < 8);
                i_mtr_walk_model.walk(LVL_UPPER, 13'h1080, r, en);
                @(posedge clk);
                chk("fetch_eff", fetch_type, eff(TY[j], r, en));
                i_mtr_walk_model.access(r, en);
                @(posedge clk);
                chk("acc_eff", acc_type, eff(TY[j], r, en));
            end
        end
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        chk("rst_acc", acc_out_valid, 1'b0);
        chk("rst_type", acc_type, 3'h0);
        rst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        miscompares = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_feature;
        t_reject;
        t_index;
        t_combine;
        do_reset;
        t_reset;
        report_and_stop;
    end
endmodule
